// ==== hbpc_core.sv ====
// Overview of operation
// R1: both low: coast, start sleep count
// R2: one input high drives forward/reverse
// R3: both high brakes through low sides
// R4: inputs low for delay enters sleep
// R5: power-up with inputs low sleeps immediately
// R6: wake after 5us hold, run 50us later
// R7: trip when sense exceeds reference over gain
// R8: trip forces low sides for off-time
// R9: after off-time, follow inputs again
// R10: dead gap between high and low drive
// R11: supply low disables all FETs
// R12: persistent overcurrent disables for retry period
// R13: retry 3ms, repeats while overcurrent persists
// R14: overtemperature disables until hysteresis clears
// R15: controller PWM at most 100kHz
// R16: controller modulates one input, brakes off-phase
// R17: controller holds each level 800ns
// R18: any fault overrides regulation and inputs
module hbpc_core #(
    parameter int SLEEP_CYCLES = hbpc_pkg::SLEEP_CYC,
    parameter int RETRY_CYCLES = hbpc_pkg::RETRY_CYC
) (
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic       clk_en_i,
    input  wire logic       dir_input_a_i,
    input  wire logic       dir_input_b_i,
    input  wire logic       current_trip_i,
    input  wire logic       supply_low_lockout_i,
    input  wire logic       overcurrent_trip_i,
    input  wire logic       overtemp_shutdown_i,
    output logic      [1:0] bridge_out_a_o,
    output logic      [1:0] bridge_out_b_o,
    output logic            sleeping_o,
    output logic            fault_o
);
    import hbpc_pkg::*;

    // three-stage synchronisers; change taken when stages 2 and 3 agree
    logic [2:0] sa, sb, st, su, so, sx;
    logic       in_a, in_b, trip, uv, oc, ot;
    logic       next_in_a, next_in_b, next_trip, next_uv, next_oc, next_ot;

    function automatic logic filt(input logic [2:0] s, input logic cur);
        filt = (s[1] == s[2]) ? s[2] : cur;
    endfunction

    always_comb begin
        next_in_a = filt(sa, in_a);
        next_in_b = filt(sb, in_b);
        next_trip = filt(st, trip);
        next_uv   = filt(su, uv);
        next_oc   = filt(so, oc);
        next_ot   = filt(sx, ot);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            {sa, sb, st, su, so, sx} <= '0;
            {in_a, in_b, trip, uv, oc, ot} <= '0;
        end else if (clk_en_i) begin
            sa <= {sa[1:0], dir_input_a_i};
            sb <= {sb[1:0], dir_input_b_i};
            st <= {st[1:0], current_trip_i};
            su <= {su[1:0], supply_low_lockout_i};
            so <= {so[1:0], overcurrent_trip_i};
            sx <= {sx[1:0], overtemp_shutdown_i};
            in_a <= next_in_a;
            in_b <= next_in_b;
            trip <= next_trip;
            uv   <= next_uv;
            oc   <= next_oc;
            ot   <= next_ot;
        end
    end

    // mode, sleep/wake, regulation and overcurrent timers
    hbpc_mode_e       mode, next_mode;
    logic [CNT_W-1:0] mcnt, next_mcnt;
    logic [CNT_W-1:0] dcnt, next_dcnt;
    logic [CNT_W-1:0] ocnt, next_ocnt;
    logic [CNT_W-1:0] rcnt, next_rcnt;
    logic             retry, next_retry;
    logic             any_in;
    logic             fault;

    assign any_in = in_a | in_b;
    assign fault  = uv | retry | ot;                                         // [R11] [R14]

    always_comb begin
        next_mode = mode;
        next_mcnt = '0;
        case (mode)
            ST_SLEEP: begin
                // input must be held for the wake hold time first
                if (any_in) begin
                    next_mcnt = mcnt + 1'b1;
                    if (mcnt >= CNT_W'(WAKE_HOLD_CYC - 1)) begin             // [R6]
                        next_mode = ST_WAKE;
                        next_mcnt = '0;
                    end
                end
            end
            ST_WAKE: begin
                next_mcnt = mcnt + 1'b1;
                if (mcnt >= CNT_W'(WAKE_CYC - 1)) begin                      // [R6]
                    next_mode = ST_RUN;
                    next_mcnt = '0;
                end
            end
            ST_RUN: begin
                if (!any_in) begin                                           // [R1]
                    next_mcnt = mcnt + 1'b1;
                    if (mcnt >= CNT_W'(SLEEP_CYCLES - 1)) begin              // [R4]
                        next_mode = ST_SLEEP;
                        next_mcnt = '0;
                    end
                end
            end
            default: next_mode = ST_SLEEP;
        endcase

        // off-time starts on a trip in run mode without a fault, coast included; trip level is analog ref/gain
        next_dcnt = dcnt;                                                    // [R7]
        if (dcnt != '0)
            next_dcnt = dcnt - 1'b1;                                         // [R9]
        else if (trip && mode == ST_RUN && !fault)
            next_dcnt = CNT_W'(DECAY_CYC);                                   // [R8]

        next_retry = retry;
        next_rcnt  = rcnt;
        next_ocnt  = oc ? ocnt + 1'b1 : '0;
        if (retry) begin
            next_ocnt = '0;
            next_rcnt = rcnt + 1'b1;
            if (rcnt >= CNT_W'(RETRY_CYCLES - 1)) begin                      // [R13]
                next_retry = 1'b0;
                next_rcnt  = '0;
            end
        end else if (oc && ocnt >= CNT_W'(DEGLITCH_CYC - 1)) begin           // [R12]
            next_retry = 1'b1;
            next_rcnt  = '0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            mode  <= ST_SLEEP;                                               // [R5]
            mcnt  <= '0;
            dcnt  <= '0;
            ocnt  <= '0;
            rcnt  <= '0;
            retry <= 1'b0;
        end else if (clk_en_i) begin
            mode  <= next_mode;
            mcnt  <= next_mcnt;
            dcnt  <= next_dcnt;
            ocnt  <= next_ocnt;
            rcnt  <= next_rcnt;
            retry <= next_retry;
        end
    end

    // target drive and dead-gap insertion per half-bridge
    logic [1:0] tgt_a, tgt_b;
    logic [1:0] next_out_a, next_out_b;
    logic [3:0] gap_a, gap_b, next_gap_a, next_gap_b;

    always_comb begin
        if (fault || mode != ST_RUN) begin                                   // [R18]
            tgt_a = HB_OFF;
            tgt_b = HB_OFF;
        end else if (dcnt != '0) begin
            tgt_a = HB_LOW;                                                  // [R8]
            tgt_b = HB_LOW;
        end else begin
            case ({in_a, in_b})
                2'h0: begin tgt_a = HB_OFF;  tgt_b = HB_OFF;  end            // [R1]
                2'h1: begin tgt_a = HB_LOW;  tgt_b = HB_HIGH; end            // [R2]
                2'h2: begin tgt_a = HB_HIGH; tgt_b = HB_LOW;  end            // [R2]
                2'h3: begin tgt_a = HB_LOW;  tgt_b = HB_LOW;  end            // [R3]
                default: begin tgt_a = HB_OFF; tgt_b = HB_OFF; end
            endcase
        end
    end

    function automatic logic [5:0] step(input logic [1:0] cur, input logic [1:0] tgt,
                                        input logic [3:0] gap);
        // returns {out, gap}; leaving any driven level runs the full gap, so a
        // one-cycle coast between high and low cannot shorten the dead time
        if (gap != '0)
            step = {HB_OFF, gap - 4'h1};
        else if (cur != HB_OFF && cur != tgt)
            step = {HB_OFF, 4'(GAP_CYC - 1)};                                // [R10]
        else
            step = {tgt, 4'h0};
    endfunction

    always_comb begin
        {next_out_a, next_gap_a} = step(bridge_out_a_o, tgt_a, gap_a);
        {next_out_b, next_gap_b} = step(bridge_out_b_o, tgt_b, gap_b);
        // faults cut drive at once, no gap needed to turn off
        if (fault) begin                                                     // [R18]
            next_out_a = HB_OFF;
            next_out_b = HB_OFF;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            bridge_out_a_o <= HB_OFF;
            bridge_out_b_o <= HB_OFF;
            gap_a <= '0;
            gap_b <= '0;
        end else if (clk_en_i) begin
            bridge_out_a_o <= next_out_a;
            bridge_out_b_o <= next_out_b;
            gap_a <= next_gap_a;
            gap_b <= next_gap_b;
        end
    end

    assign sleeping_o = (mode == ST_SLEEP);
    assign fault_o    = fault;

    a_fault_cuts_drive: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R18]
        clk_en_i && fault |=> bridge_out_a_o == HB_OFF && bridge_out_b_o == HB_OFF)
        else $error("drive present during fault");
    a_no_direct_swap: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R10]
        bridge_out_a_o == HB_HIGH |=> bridge_out_a_o != HB_LOW)
        else $error("half-bridge swapped without gap");
    a_sleep_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R4]
        mode == ST_SLEEP ##1 mode == ST_SLEEP |-> bridge_out_a_o == HB_OFF
        && bridge_out_b_o == HB_OFF)
        else $error("drive while asleep");
    a_trip_brake: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R8]
        clk_en_i && dcnt != '0 && mode == ST_RUN && !fault && gap_a == '0
        && bridge_out_a_o != HB_HIGH |=> bridge_out_a_o == HB_LOW)
        else $error("no brake during off-time");
    a_retry_len: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R13]
        $fell(retry) |-> $past(rcnt) == CNT_W'(RETRY_CYCLES - 1))
        else $error("retry period length wrong");
    a_oc_deglitch: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R12]
        $rose(retry) |-> $past(ocnt) == CNT_W'(DEGLITCH_CYC - 1))
        else $error("retry started before deglitch time");
    sequence s_high_released;
        bridge_out_a_o == HB_HIGH ##1 bridge_out_a_o != HB_HIGH;
    endsequence
    a_gap_hold: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R10]
        s_high_released |-> (bridge_out_a_o != HB_LOW) [*5])
        else $error("gap shorter than dead time");
    a_wake_order: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R6]
        mode == ST_SLEEP ##1 mode != ST_SLEEP |-> mode == ST_WAKE)
        else $error("sleep left without wake delay");
    a_forward: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R2]
        clk_en_i && tgt_a == HB_HIGH && bridge_out_a_o == HB_HIGH && !fault
        |=> bridge_out_a_o != HB_LOW)
        else $error("forward drive broken");
    a_uv_off: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // [R11]
        clk_en_i && uv |=> bridge_out_b_o == HB_OFF)
        else $error("drive during supply low");
endmodule

// ==== hbpc_pkg.sv ====
package hbpc_pkg;
    localparam int CLK_HZ              = 20_000_000;
    localparam int CLK_NS              = 50;
    // times in their own units, cycle counts derived
    localparam int SLEEP_DELAY_US      = 1000;
    localparam int WAKE_HOLD_US        = 5;
    localparam int WAKE_DELAY_US       = 50;
    localparam int DECAY_OFF_TIME_US   = 25;
    localparam int TRANSITION_GAP_NS   = 220;
    localparam int OC_DEGLITCH_NS      = 1500;
    localparam int OC_RETRY_US         = 3000;
    localparam int TRIP_GAIN           = 10;
    localparam int SLEEP_CYC    = SLEEP_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int WAKE_HOLD_CYC = WAKE_HOLD_US * (CLK_HZ / 1_000_000);
    localparam int WAKE_CYC     = WAKE_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int DECAY_CYC    = DECAY_OFF_TIME_US * (CLK_HZ / 1_000_000);
    localparam int GAP_CYC      = (TRANSITION_GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEGLITCH_CYC = (OC_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RETRY_CYC    = OC_RETRY_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W        = 17;
    // half-bridge drive codes
    localparam logic [1:0] HB_OFF  = 2'h0;
    localparam logic [1:0] HB_LOW  = 2'h1;
    localparam logic [1:0] HB_HIGH = 2'h2;
    typedef enum {ST_SLEEP, ST_WAKE, ST_RUN} hbpc_mode_e;
endpackage

// ==== hbpc_ctrl_model.sv ====
// controller side: applies requested levels, never sooner than the minimum hold
module hbpc_ctrl_model #(
    // 100 cycles a level: well over 800 ns, and a period of at least 10 us
    parameter int MIN_HOLD = 100
) (
    input  wire logic sys_clk_i,
    input  wire logic req_a_i,
    input  wire logic req_b_i,
    output logic      dir_input_a_o,
    output logic      dir_input_b_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int held = MIN_HOLD;
    initial begin
        dir_input_a_o = 1'b0;
        dir_input_b_o = 1'b0;
    end
    // a late request waits, so edges never come faster than the detector sees
    always @(negedge sys_clk_i) begin
        if (held < MIN_HOLD) begin
            held <= held + 1;
        end else if ({req_a_i, req_b_i} != {dir_input_a_o, dir_input_b_o}) begin
            dir_input_a_o <= req_a_i;
            dir_input_b_o <= req_b_i;
            held          <= 1;
        end
    end
endmodule

// ==== tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import hbpc_pkg::*;
    localparam int SLP = 300;
    localparam int RTY = 40;
    logic        sys_clk_i = 1'b0;
    logic        resetn_i  = 1'b0;
    logic        ra = 1'b0, rb = 1'b0, trip = 1'b0, uv = 1'b0, oc = 1'b0, ot = 1'b0;
    logic        en = 1'b1;
    logic        da, db, sleeping, fault, pf;
    logic  [1:0] oa, ob, c, prev;
    logic  [1:0] pa = 2'h0, pb = 2'h0;
    logic [31:0] lfsr = 32'hD39D;
    int          n_errors = 0, comparisons = 0, rises, fwd;
    initial forever #25 sys_clk_i = ~sys_clk_i;
    hbpc_ctrl_model hbpc_ctrl_model_i (.sys_clk_i(sys_clk_i), .req_a_i(ra), .req_b_i(rb),
        .dir_input_a_o(da), .dir_input_b_o(db));
    hbpc_core #(.SLEEP_CYCLES(SLP), .RETRY_CYCLES(RTY)) hbpc_core_i (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .clk_en_i(en),
        .dir_input_a_i(da), .dir_input_b_i(db), .current_trip_i(trip),
        .supply_low_lockout_i(uv), .overcurrent_trip_i(oc), .overtemp_shutdown_i(ot),
        .bridge_out_a_o(oa), .bridge_out_b_o(ob), .sleeping_o(sleeping), .fault_o(fault));
    function automatic logic [31:0] nxt(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [3:0] drive(logic a, logic b);
        case ({a, b})
            2'b10:   return {HB_HIGH, HB_LOW};
            2'b01:   return {HB_LOW, HB_HIGH};
            2'b11:   return {HB_LOW, HB_LOW};
            default: return {HB_OFF, HB_OFF};
        endcase
    endfunction
    task automatic finish_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(logic [4:0] seen, logic [4:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    // bounded wait for outputs and sleep flag; a used-up bound ends the run
    task automatic wait_st(logic [4:0] exp, int bound);
        int i;
        for (i = 0; i < bound && {oa, ob, sleeping} !== exp; i++) cyc(1);
        check({oa, ob, sleeping}, exp);
        if ({oa, ob, sleeping} !== exp) finish_test();
    endtask
    // a direct high-to-low swap shows as code xor 3
    always @(negedge sys_clk_i) begin
        if ((pa ^ oa) == 2'h3 || (pb ^ ob) == 2'h3) check(5'h1, 5'h0);
        pa <= oa;
        pb <= ob;
    end
    initial begin
        cyc(2);
        resetn_i = 1'b1;
        cyc(1);
        check({oa, ob, sleeping}, {HB_OFF, HB_OFF, 1'b1});
        ra <= 1'b1;
        cyc(90);
        check({oa, ob, sleeping}, {HB_OFF, HB_OFF, 1'b1});
        wait_st({HB_OFF, HB_OFF, 1'b0}, 40);
        cyc(900);
        check({oa, ob, sleeping}, {HB_OFF, HB_OFF, 1'b0});
        wait_st({drive(1, 0), 1'b0}, 300);
        prev = 2'b10;
        for (int k = 0; k < 24; k++) begin
            lfsr = nxt(lfsr);
            c = (k == 0) ? 2'b01 : lfsr[1:0];
            if (c == 2'b00 && prev == 2'b00) c = 2'b11;
            {ra, rb} <= c;
            wait_st({drive(c[1], c[0]), 1'b0}, 30);
            cyc(int'(lfsr[4:2]) + 100);
            prev = c;
        end
        {ra, rb} <= 2'b10;
        wait_st({drive(1, 0), 1'b0}, 40);
        // one input switched, the other static, brake in the off phase
        for (int p = 0; p < 4; p++) begin
            cyc(100);
            rb <= ~p[0];
            wait_st({drive(1'b1, ~p[0]), 1'b0}, 30);
        end
        trip = 1'b1;
        cyc(2);
        trip = 1'b0;
        wait_st({HB_LOW, HB_LOW, 1'b0}, 20);
        cyc(470);
        check({oa, ob, sleeping}, {HB_LOW, HB_LOW, 1'b0});
        wait_st({drive(1, 0), 1'b0}, 60);
        for (int f = 0; f < 2; f++) begin
            trip = 1'b1;
            cyc(2);
            trip = 1'b0;
            if (f == 0) uv = 1'b1;
            else ot = 1'b1;
            wait_st({HB_OFF, HB_OFF, 1'b0}, 15);
            check({4'h0, fault}, 5'h1);
            cyc(520);
            check({oa, ob, sleeping}, {HB_OFF, HB_OFF, 1'b0});
            {uv, ot} = 2'b00;
            wait_st({drive(1, 0), 1'b0}, 30);
        end
        oc = 1'b1;
        wait_st({HB_OFF, HB_OFF, 1'b0}, 50);
        check({4'h0, fault}, 5'h1);
        rises = 0;
        fwd = 0;
        for (int i = 0; i < 200; i++) begin
            pf = fault;
            cyc(1);
            if (!pf && fault) rises++;
            if ({oa, ob} == drive(1, 0)) fwd++;
        end
        check({4'h0, rises >= 2}, 5'h1);
        check({4'h0, fwd >= 30}, 5'h1);
        oc = 1'b0;
        wait_st({drive(1, 0), 1'b0}, RTY + 40);
        {ra, rb} <= 2'b00;
        cyc(30);
        check({oa, ob, sleeping}, {HB_OFF, HB_OFF, 1'b0});
        wait_st({HB_OFF, HB_OFF, 1'b1}, SLP + 40);
        // clock enable low must freeze the wake hold count
        en = 1'b0;
        ra <= 1'b1;
        cyc(200);
        check({oa, ob, sleeping}, {HB_OFF, HB_OFF, 1'b1});
        en = 1'b1;
        wait_st({HB_OFF, HB_OFF, 1'b0}, 150);
        finish_test();
    end
endmodule
